// [logic/socket_status_snapshot.sv]
/*
  Socket present-state register bank with its event, mask, force-event
  and control neighbours, on an Avalon-MM slave with waitrequest.
  Assumes card pins synchronous to clock_i; card type and voltage
  sense results arrive as levels valid when interrogation ends.
*/
// Notes on behaviour
// - Force-event writes at 0Ch update the present-state contents only with all four byte enables set.
// - Card voltage and type fields change only at interrogation or on a force write.
// - Detect line changes during identification do not reach the register.
// - Bits 31 and 30 always read zero.
// - Bits 29 and 28 read set unless changed by a write at 14h.
// - Bit 27 shows video port support.
// - Bits 13 to 10 show the card's supported supply voltages.
// - Bit 9 flags an invalid supply request from software.
// - Bit 8 flags possible data loss on removal.
// - Bit 7 flags an unrecognised card until a valid one arrives.
// - Bit 6 shows the live ready/interrupt line.
// - Bit 5 flags a CardBus card until next interrogation.
// - Bit 4 flags a 16-bit card until next interrogation.
// - Bit 3 shows socket power, zero after reset.
// - Bits 2 and 1 mirror the detect lines.
// - Bit 0 mirrors the status-change line.
// - Force bits 13 to 4, except 6, copy into present-state.
// - Force bit 14 re-runs interrogation and refreshes the register.
// - Changes of bits 3 to 0 set socket event flags.
`timescale 1ns/1ps
`include "socket_status_regs.svh"

module socket_status_snapshot #(
  parameter int IDENT_CYCLES = `IDENT_CYCLES,
  parameter bit VIDEO_CAPABLE = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic detect_line_a_b_i,
  input wire logic detect_line_b_b_i,
  input wire logic status_change_line_i,
  input wire logic ready_irq_line_i,
  input wire logic [3:0] card_volt_sense_i,
  input wire logic card_is_cardbus_i,
  input wire logic card_is_sixteen_i,
  input wire logic card_unrecognised_i,
  input wire logic removal_loss_i,
  output logic [3:0] socket_event_o,
  output logic socket_powered_o
);

  // ===========================================================
  // Elaboration checks
  if (IDENT_CYCLES < 1 || IDENT_CYCLES > 65535) begin : g_bad_ident
    $error("IDENT_CYCLES out of range");
  end

  // ===========================================================
  // Bus handshake: one wait cycle then answer
  logic ack_ff;
  logic waitreq_ff;
  logic [31:0] rdata_ff;
  wire logic req = avs_read_i | avs_write_i;
  wire logic wr_take = avs_write_i & ack_ff;
  wire logic all_bytes = &avs_byteenable_i;
  // Address decode shared by the write strobes and the read mux
  wire logic hit_event = (avs_address_i == `OFS_EVENT);
  wire logic hit_mask = (avs_address_i == `OFS_MASK);
  wire logic hit_snapshot = (avs_address_i == `OFS_SNAPSHOT);
  wire logic hit_force = (avs_address_i == `OFS_FORCE);
  wire logic hit_ctrl = (avs_address_i == `OFS_CTRL);
  wire logic hit_hwcfg = (avs_address_i == `OFS_HWCFG);
  wire logic wr_event = wr_take & hit_event;
  wire logic wr_mask = wr_take & hit_mask;
  wire logic wr_force = wr_take & hit_force & all_bytes;
  wire logic wr_ctrl = wr_take & hit_ctrl;
  wire logic wr_hwcfg = wr_take & hit_hwcfg;

  // Waitrequest has its own flop so the port is registered, not inverted
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      ack_ff <= 1'b0;
      waitreq_ff <= 1'b1;
    end else begin
      ack_ff <= req & ~ack_ff;
      waitreq_ff <= ~(req & ~ack_ff);
    end
  end

  assign avs_waitrequest_o = waitreq_ff;

  // ===========================================================
  // Interrogation sequencer
  logic ident_busy;
  logic ident_done;
  logic det_a_ff;
  logic det_b_ff;
  wire logic det_a_next = ident_busy ? det_a_ff : detect_line_a_b_i;
  wire logic det_b_next = ident_busy ? det_b_ff : detect_line_b_b_i;
  wire logic both_present = ~detect_line_a_b_i & ~detect_line_b_b_i;
  wire logic was_absent = det_a_ff & det_b_ff;
  // Insertion is seen only when both pins leave the empty state together
  wire logic insertion = both_present & was_absent & ~ident_busy;
  wire logic retest = wr_force & avs_writedata_i[`BIT_RETEST];
  wire logic start_ident = insertion | retest;

  card_ident_fsm #(
    .IDENT_CYCLES(IDENT_CYCLES)
  ) u_ident (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .start_i(start_ident),
    .busy_o(ident_busy),
    .done_o(ident_done)
  );

  // ===========================================================
  // Socket capability and control
  logic [1:0] sock_cap_ff;
  logic video_ff;
  logic power_ff;
  logic [2:0] volt_sel_ff;

  // Selected voltage legal only if the card advertises it
  function automatic logic volt_invalid(input logic [2:0] sel, input logic [3:0] ok);
    case (sel)
      3'h0: volt_invalid = 1'b0;
      3'h2: volt_invalid = ~ok[0];
      3'h3: volt_invalid = ~ok[1];
      3'h4: volt_invalid = ~ok[2];
      3'h5: volt_invalid = ~ok[3];
      default: volt_invalid = 1'b1;
    endcase
  endfunction

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sock_cap_ff <= {`HWCFG_SOCK_THREE, `HWCFG_SOCK_FIVE};
    end else if (wr_hwcfg) begin
      sock_cap_ff <= avs_writedata_i[1:0];
    end
  end

  // Video support can only be claimed where the socket has the port
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      video_ff <= 1'b0;
    end else if (wr_force) begin
      video_ff <= avs_writedata_i[`BIT_VIDEO] & VIDEO_CAPABLE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      volt_sel_ff <= 3'h0;
      power_ff <= 1'b0;
    end else if (wr_ctrl) begin
      volt_sel_ff <= avs_writedata_i[`CTRL_VOLT_MSB:`CTRL_VOLT_LSB];
      power_ff <= avs_writedata_i[`CTRL_POWER_BIT];
    end
  end

  // ===========================================================
  // Present-state fields
  logic [3:0] card_ok_ff;
  logic bad_req_ff;
  logic loss_ff;
  logic not_card_ff;
  logic cb_ff;
  logic sixteen_ff;
  logic ready_ff;
  logic sts_ff;
  wire logic [31:0] fw = avs_writedata_i;
  wire logic [2:0] ctrl_sel = fw[`CTRL_VOLT_MSB:`CTRL_VOLT_LSB];
  wire logic nxt_bad_req = (wr_ctrl & volt_invalid(ctrl_sel, card_ok_ff))
                           | (bad_req_ff & ~(wr_ctrl & (ctrl_sel == 3'h0)));
  wire logic unrec_set = ident_done & card_unrecognised_i;
  wire logic valid_card = card_is_cardbus_i | card_is_sixteen_i;

  // Detect bits hold while busy, so a bouncing pin cannot leak in
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      det_a_ff <= 1'b1;
      det_b_ff <= 1'b1;
      ready_ff <= 1'b0;
      sts_ff <= 1'b0;
    end else begin
      det_a_ff <= det_a_next;
      det_b_ff <= det_b_next;
      ready_ff <= ready_irq_line_i;
      sts_ff <= status_change_line_i;
    end
  end

  // A force write overrides an interrogation result landing at once
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      card_ok_ff <= 4'h0;
      cb_ff <= 1'b0;
      sixteen_ff <= 1'b0;
    end else if (wr_force) begin
      card_ok_ff <= fw[`BIT_CARD_YY:`BIT_CARD_FIVE];
      cb_ff <= fw[`BIT_CB];
      sixteen_ff <= fw[`BIT_SIXTEEN];
    end else if (ident_done) begin
      card_ok_ff <= card_volt_sense_i;
      cb_ff <= card_is_cardbus_i;
      sixteen_ff <= card_is_sixteen_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      bad_req_ff <= 1'b0;
    end else if (wr_force) begin
      bad_req_ff <= fw[`BIT_BADREQ];
    end else begin
      bad_req_ff <= nxt_bad_req;
    end
  end

  // Hardware sets win over a force write of zero in the same cycle
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      loss_ff <= 1'b0;
    end else if (wr_force) begin
      loss_ff <= fw[`BIT_LOSS] | removal_loss_i;
    end else if (removal_loss_i) begin
      loss_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      not_card_ff <= 1'b0;
    end else if (wr_force) begin
      not_card_ff <= fw[`BIT_NOTCARD] | unrec_set;
    end else if (unrec_set) begin
      not_card_ff <= 1'b1;
    end else if (ident_done & valid_card) begin
      not_card_ff <= 1'b0;
    end
  end

  // ===========================================================
  // Event and mask
  logic [3:0] mask_ff;
  logic [3:0] evt;
  wire logic [3:0] evt_level = {power_ff, det_b_ff, det_a_ff, sts_ff};
  // Force bits 3:0 set events without touching the mirrored levels
  wire logic [3:0] evt_force = {4{wr_force}} & fw[3:0];
  wire logic [3:0] evt_clear = {4{wr_event}} & fw[3:0];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_evt
      edge_flag u_flag (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .level_i(evt_level[gi]),
        .force_i(evt_force[gi]),
        .clear_i(evt_clear[gi]),
        .flag_o(evt[gi])
      );
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      mask_ff <= 4'h0;
    end else if (wr_mask) begin
      mask_ff <= fw[3:0];
    end
  end

  // ===========================================================
  // Read mux
  wire logic [1:0] future_volt = 2'b00;
  wire logic [12:0] reserved_field = 13'h0000;
  wire logic [31:0] snapshot = {
    future_volt,
    sock_cap_ff,
    video_ff,
    reserved_field,
    card_ok_ff,
    bad_req_ff,
    loss_ff,
    not_card_ff,
    ready_ff,
    cb_ff,
    sixteen_ff,
    power_ff,
    det_b_ff,
    det_a_ff,
    sts_ff
  };
  wire logic [31:0] event_word = {28'h0000000, evt};
  wire logic [31:0] mask_word = {28'h0000000, mask_ff};
  wire logic [31:0] ctrl_word = {25'h0000000, volt_sel_ff, 3'h0, power_ff};
  wire logic [31:0] hwcfg_word = {30'h00000000, sock_cap_ff};
  wire logic [31:0] rd_mux =
    hit_event ? event_word :
    hit_mask ? mask_word :
    hit_snapshot ? snapshot :
    hit_ctrl ? ctrl_word :
    hit_hwcfg ? hwcfg_word :
    32'h00000000; // Snapshot writes fall through as no-ops
  // Read data is captured in the first request cycle and held until the next read
  wire logic rd_capture = avs_read_i & ~ack_ff;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rdata_ff <= 32'h00000000;
    end else if (rd_capture) begin
      rdata_ff <= rd_mux;
    end
  end

  // ===========================================================
  // Outputs
  logic [3:0] evt_out_ff;
  // Mask gates only the event pins, never the event register itself
  wire logic [3:0] nxt_evt_out = evt & mask_ff;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      evt_out_ff <= 4'h0;
    end else begin
      evt_out_ff <= nxt_evt_out;
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign socket_event_o = evt_out_ff;
  assign socket_powered_o = power_ff;

endmodule // socket_status_snapshot

// [logic/socket_status_regs.svh]
/*
  Register map constants for the socket present-state register bank.
  Assumes inclusion by bare name from design files under logic/.
*/
`ifndef SOCKET_STATUS_REGS_SVH
`define SOCKET_STATUS_REGS_SVH

`define OFS_EVENT 8'h00
`define OFS_MASK 8'h04
`define OFS_SNAPSHOT 8'h08
`define OFS_FORCE 8'h0C
`define OFS_CTRL 8'h10
`define OFS_HWCFG 8'h14

`define BIT_YY_SOCK 31
`define BIT_XX_SOCK 30
`define BIT_THREE_SOCK 29
`define BIT_FIVE_SOCK 28
`define BIT_VIDEO 27
`define BIT_RETEST 14
`define BIT_CARD_YY 13
`define BIT_CARD_FIVE 10
`define BIT_BADREQ 9
`define BIT_LOSS 8
`define BIT_NOTCARD 7
`define BIT_READY 6
`define BIT_CB 5
`define BIT_SIXTEEN 4
`define BIT_POWER 3
`define BIT_DET_B 2
`define BIT_DET_A 1
`define BIT_STS 0

`define CTRL_POWER_BIT 0
`define CTRL_VOLT_LSB 4
`define CTRL_VOLT_MSB 6

`define HWCFG_SOCK_THREE 1'b1
`define HWCFG_SOCK_FIVE 1'b1
`define HWCFG_RESET 4'h3

`define IDENT_TIME_NS 2000
`define IDENT_CYCLES (((`IDENT_TIME_NS) + 9) / 10)

`endif

// [logic/socket_status_pkg.sv]
/*
  Types shared by the socket present-state bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package socket_status_pkg;
  typedef enum logic [1:0] {
    IDLE,
    IDENTIFY,
    LATCH
  } ident_state_e;

  typedef logic [31:0] word_t;
endpackage

// [logic/card_ident_fsm.sv]
/*
  Card interrogation sequencer: runs on insertion or retest request,
  holds busy for a fixed identify window plus a latch cycle, pulsing done in the latch cycle.
  Assumes detect levels synchronous to clock_i.
*/
`timescale 1ns/1ps
`include "socket_status_regs.svh"

module card_ident_fsm #(
  parameter int IDENT_CYCLES = `IDENT_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);

  if (IDENT_CYCLES < 1 || IDENT_CYCLES > 65535) begin : g_bad_cycles
    $error("IDENT_CYCLES must lie between 1 and 65535");
  end

  socket_status_pkg::ident_state_e state_ff;
  socket_status_pkg::ident_state_e nxt_state;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  wire logic cnt_end = (cnt_ff == 16'(IDENT_CYCLES - 1));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      socket_status_pkg::IDLE: begin
        nxt_cnt = 16'h0000;
        if (start_i) begin
          nxt_state = socket_status_pkg::IDENTIFY;
        end
      end
      socket_status_pkg::IDENTIFY: begin
        nxt_cnt = cnt_ff + 16'h0001;
        if (cnt_end) begin
          nxt_state = socket_status_pkg::LATCH;
        end
      end
      socket_status_pkg::LATCH: begin
        nxt_state = socket_status_pkg::IDLE;
      end
      default: begin
        nxt_state = socket_status_pkg::IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_ff <= socket_status_pkg::IDLE;
      cnt_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy_o = (state_ff != socket_status_pkg::IDLE);
  assign done_o = (state_ff == socket_status_pkg::LATCH);

endmodule // card_ident_fsm

// [logic/edge_flag.sv]
/*
  Sticky change flag: set on a change of the watched level or a force,
  cleared by write-one; set wins over clear.
  Assumes all inputs synchronous to clock_i.
*/
`timescale 1ns/1ps

module edge_flag (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic level_i,
  input wire logic force_i,
  input wire logic clear_i,
  output logic flag_o
);

  logic prev_ff;
  logic flag_ff;
  wire logic changed = (level_i != prev_ff);

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      // Start from the watched level so leaving reset raises no false change
      prev_ff <= level_i;
      flag_ff <= 1'b0;
    end else begin
      prev_ff <= level_i;
      flag_ff <= (changed | force_i) | (flag_ff & ~clear_i);
    end
  end

  assign flag_o = flag_ff;

endmodule // edge_flag

// [sim/socket_status_asserts.sv]
/* Port assertions for the socket present-state bank.
   Bound to socket_status_snapshot from the bench top file. */
`timescale 1ns/1ps
module socket_status_asserts #(
  parameter bit VIDEO_CAPABLE = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic detect_line_a_b_i,
  input wire logic detect_line_b_b_i,
  input wire logic status_change_line_i,
  input wire logic ready_irq_line_i,
  input wire logic removal_loss_i,
  input wire logic socket_powered_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================
  // Forced field tracking
  logic [31:0] forced_ff;
  logic forced_ok_ff;
  logic [1:0] det_ff;
  wire [1:0] det_w = {detect_line_b_b_i, detect_line_a_b_i};
  wire done_w = avs_write_i & !avs_waitrequest_o;
  wire snap_rd = avs_read_i & !avs_waitrequest_o & (avs_address_i == 8'h08);
  wire force_wr = done_w & (avs_address_i == 8'h0C);
  wire spoil_w = (done_w & (avs_address_i == 8'h10)) | removal_loss_i | (det_ff != det_w);
  always_ff @(posedge clock_i) begin
    det_ff <= det_w;
    forced_ff <= force_wr ? avs_writedata_i : forced_ff;
    forced_ok_ff <= (!rst_b_i | spoil_w) ? 1'b0 : (force_wr ? ~avs_writedata_i[14] : forced_ok_ff);
  end
  // ==========================================
  // Assertions
  future_volt_zero_a: assert property (snap_rd |-> avs_readdata_o[31:30] == 2'b00)
    else $error("snapshot bits 31:30 not zero");
  reserved_zero_a: assert property (snap_rd |-> avs_readdata_o[26:14] == 13'h0)
    else $error("snapshot reserved field not zero");
  video_bit_a: assert property (snap_rd && !VIDEO_CAPABLE |-> !avs_readdata_o[27])
    else $error("video bit set without support");
  ready_mirror_a: assert property (snap_rd && $stable(ready_irq_line_i)
      && $past(ready_irq_line_i, 2) == ready_irq_line_i |-> avs_readdata_o[6] == ready_irq_line_i)
    else $error("ready line level not mirrored");
  status_mirror_a: assert property (snap_rd && $stable(status_change_line_i)
      && $past(status_change_line_i, 2) == status_change_line_i
      |-> avs_readdata_o[0] == status_change_line_i)
    else $error("status line level not mirrored");
  empty_detect_a: assert property (snap_rd && det_w == 2'b11
      && $past(det_w, 1) == 2'b11 && $past(det_w, 2) == 2'b11 |-> avs_readdata_o[2:1] == 2'b11)
    else $error("detect bits not high with empty socket");
  power_bit_a: assert property (snap_rd && $stable(socket_powered_o)
      && $past(socket_powered_o, 2) == socket_powered_o |-> avs_readdata_o[3] == socket_powered_o)
    else $error("power bit disagrees with power output");
  forced_copy_a: assert property (snap_rd && forced_ok_ff
      |-> (avs_readdata_o & 32'h3DB0) == (forced_ff & 32'h3DB0))
    else $error("forced fields not in snapshot");
endmodule // socket_status_asserts

// [sim/card_socket_model.sv]
/* Behavioural card in the socket: detect pins, sense and type levels.
   Assumes the bench commands insertion, card kind and a detect bounce. */
`timescale 1ns/1ps
module card_socket_model (
  input wire logic clock_i,
  input wire logic inserted_i,
  input wire logic bounce_i,
  input wire logic [3:0] volt_i,
  input wire logic cardbus_i,
  input wire logic sixteen_i,
  input wire logic unrec_i,
  output logic detect_line_a_b_o,
  output logic detect_line_b_b_o,
  output logic [3:0] card_volt_sense_o,
  output logic card_is_cardbus_o,
  output logic card_is_sixteen_o,
  output logic card_unrecognised_o
);
  logic seated_ff = 1'b0;
  always_ff @(posedge clock_i) begin
    seated_ff <= inserted_i;
  end
  // Detect pins pulled up when empty; both seat a cycle after the command
  assign detect_line_a_b_o = ~seated_ff;
  assign detect_line_b_b_o = ~seated_ff | bounce_i;
  // Sense and type lines pulled low with no card
  assign card_volt_sense_o = inserted_i ? volt_i : 4'h0;
  assign card_is_cardbus_o = inserted_i & cardbus_i;
  assign card_is_sixteen_o = inserted_i & sixteen_i;
  assign card_unrecognised_o = inserted_i & unrec_i;
endmodule // card_socket_model

// [sim/tb.sv]
/* Bench top: card model, snapshot bank, checker bind, directed and random tests.
   Assumes the design under logic/ and the checker under sim/. */
`timescale 1ns/1ps
module tb;
  localparam int IDENT = 16;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata, q, q2, frc;
  logic wt, det_a, det_b, is_cb, is_sx, is_un, pw;
  logic sts = 1'b0, rdy = 1'b0, loss = 1'b0, ins = 1'b0, bounce = 1'b0;
  logic cb = 1'b0, sxt = 1'b0, unrec = 1'b0;
  logic [3:0] volt = 4'h0;
  logic [3:0] sense, ev;
  int num_errors = 0;
  int num_checks = 0;
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  card_socket_model u_card (.clock_i(clock_i), .inserted_i(ins), .bounce_i(bounce),
    .volt_i(volt), .cardbus_i(cb), .sixteen_i(sxt), .unrec_i(unrec),
    .detect_line_a_b_o(det_a), .detect_line_b_b_o(det_b), .card_volt_sense_o(sense),
    .card_is_cardbus_o(is_cb), .card_is_sixteen_o(is_sx), .card_unrecognised_o(is_un));
  socket_status_snapshot #(.IDENT_CYCLES(IDENT)) u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
    .detect_line_a_b_i(det_a), .detect_line_b_b_i(det_b), .status_change_line_i(sts),
    .ready_irq_line_i(rdy), .card_volt_sense_i(sense), .card_is_cardbus_i(is_cb),
    .card_is_sixteen_i(is_sx), .card_unrecognised_i(is_un), .removal_loss_i(loss),
    .socket_event_o(ev), .socket_powered_o(pw));
  // ==========================================
  // Checking and bus tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wd <= d;
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge clock_i);
      n++;
    end while (wt !== 1'b0 && n < 40);
    if (wt !== 1'b0) begin
      num_errors++;
      complete_run();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clock_i);
  endtask
  // ==========================================
  // Scenarios
  initial begin
    void'($urandom(32'h590B97EE));
    repeat (6) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    bus(1'b0, 8'h08, 32'h0);
    chk("reset snapshot", q, 32'h30000006);
    bus(1'b1, 8'h08, $urandom());
    bus(1'b0, 8'h08, 32'h0);
    chk("write ignored", q, 32'h30000006);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped read", q, 32'h0);
    $display("test readonly done");
    repeat (8) begin
      sts <= 1'($urandom());
      rdy <= 1'($urandom());
      repeat (3) @(posedge clock_i);
      bus(1'b0, 8'h08, 32'h0);
      chk("live lines", q & 32'h41, {25'h0, rdy, 5'h0, sts});
    end
    $display("test live lines done");
    volt <= 4'($urandom());
    cb <= 1'b1;
    ins <= 1'b1;
    repeat (5) @(posedge clock_i);
    bus(1'b0, 8'h08, 32'h0);
    q2 = q;
    bounce <= 1'b1;
    repeat (2) @(posedge clock_i);
    bus(1'b0, 8'h08, 32'h0);
    bounce <= 1'b0;
    chk("detect frozen", q & 32'h6, q2 & 32'h6);
    repeat (IDENT + 4) @(posedge clock_i);
    bus(1'b0, 8'h08, 32'h0);
    chk("card fields", q & 32'h3C36, {18'h0, volt, 10'h020});
    volt <= ~volt;
    cb <= 1'b0;
    sxt <= 1'b1;
    repeat (4) @(posedge clock_i);
    bus(1'b0, 8'h08, 32'h0);
    chk("fields held", q & 32'h3C30, {18'h0, ~volt, 10'h020});
    $display("test insertion done");
    repeat (4) begin
      frc = $urandom() & 32'h3FB0;
      bus(1'b1, 8'h0C, frc);
      bus(1'b0, 8'h08, 32'h0);
      chk("forced fields", q & 32'h3FB0, frc);
    end
    bus(1'b1, 8'h0C, 32'h4000);
    repeat (IDENT + 4) @(posedge clock_i);
    bus(1'b0, 8'h08, 32'h0);
    chk("retest fields", q & 32'h3C30, {18'h0, volt, 10'h010});
    $display("test force done");
    bus(1'b1, 8'h04, 32'hF);
    bus(1'b1, 8'h00, 32'hF);
    bus(1'b1, 8'h10, 32'h21);
    chk("powered pin", {31'h0, pw}, 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    chk("power bit", q & 32'h208, {22'h0, ~volt[0], 5'h0, 1'b1, 3'h0});
    bus(1'b0, 8'h00, 32'h0);
    chk("power event", q & 32'h8, 32'h8);
    chk("event pin", {28'h0, ev} & 32'h8, 32'h8);
    bus(1'b1, 8'h10, 32'h71);
    bus(1'b0, 8'h08, 32'h0);
    chk("bad supply", q & 32'h200, 32'h200);
    $display("test power done");
    bus(1'b1, 8'h0C, 32'h0);
    loss <= 1'b1;
    @(posedge clock_i);
    loss <= 1'b0;
    bus(1'b0, 8'h08, 32'h0);
    chk("loss flag", q & 32'h100, 32'h100);
    ins <= 1'b0;
    repeat (4) @(posedge clock_i);
    bus(1'b0, 8'h08, 32'h0);
    chk("removed", q & 32'h6, 32'h6);
    unrec <= 1'b1;
    ins <= 1'b1;
    repeat (IDENT + 8) @(posedge clock_i);
    bus(1'b0, 8'h08, 32'h0);
    chk("unknown card", q & 32'h80, 32'h80);
    $display("test removal done");
    complete_run();
  end
endmodule // tb

bind socket_status_snapshot socket_status_asserts #(.VIDEO_CAPABLE(VIDEO_CAPABLE)) u_chk (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .detect_line_a_b_i(detect_line_a_b_i), .detect_line_b_b_i(detect_line_b_b_i),
  .status_change_line_i(status_change_line_i), .ready_irq_line_i(ready_irq_line_i),
  .removal_loss_i(removal_loss_i), .socket_powered_o(socket_powered_o));
